// file: design/aacs_regs.vh
// Register offsets, field positions, reset values and timing counts of the sequencer.
`ifndef AACS_REGS_VH
`define AACS_REGS_VH

// Avalon-MM byte addresses, one aligned word per register.
`define AACS_ADDR_W        5
`define AACS_OFS_CTRL0     5'h00
`define AACS_OFS_CTRL1     5'h04
`define AACS_OFS_CTRL2     5'h08
`define AACS_OFS_RESULT    5'h0c
`define AACS_OFS_STATUS    5'h10
`define AACS_OFS_PORT      5'h14

// Control register zero fields.
`define AACS_C0_ON         0
`define AACS_C0_GO         1
`define AACS_C0_CHS_LO     2
`define AACS_C0_CHS_HI     5

// Control register two fields.
`define AACS_C2_CS_LO      0
`define AACS_C2_CS_HI      2
`define AACS_C2_ACQ_LO     3
`define AACS_C2_ACQ_HI     5

// Status register fields.
`define AACS_ST_DONE       0

// Reset values.
`define AACS_CFG_RST_ANA   4'h0
`define AACS_CFG_RST_DIG   4'h7
`define AACS_C2_RST        6'h00
`define AACS_CHS_RST       4'h0
`define AACS_RES_RST       10'h000

// Widths of the port and the result.
`define AACS_PINS          11
`define AACS_RES_W         10

// Timing counts, in conversion bit periods or oscillator periods.
`define AACS_CONV_TADS     5'h0b
`define AACS_RECOV_TADS    5'h02
`define AACS_TCY_OSC       5'h04

`endif

// file: design/aacs_sequencer.v
// Acquisition and conversion sequencer of a 10-bit successive-approximation converter.
// Function
// [R1] Software samples a new channel long enough first.
// [R2] Holding capacitor disconnects when conversion begins.
// [R3] Acquisition select zero: go starts conversion immediately.
// [R4] Nonzero select: sample selected periods, then convert.
// [R5] Select codes map to 0,2,4,6,8,12,16,20 periods.
// [R6] Completion clears go, sets done, resumes sampling.
// [R7] No status separates acquisition from conversion.
// [R8] A conversion lasts eleven bit periods.
// [R9] Clock select maps oscillator dividers or RC.
// [R10] Software picks shortest period above two microseconds.
// [R11] RC clock above 1 MHz: sleep whole conversion.
// [R12] Keep same device clock until conversion ends.
// [R13] Below 1 MHz software selects the RC clock.
// [R14] RC with zero acquisition delays one instruction cycle.
// [R15] Software clears idle-on-sleep before setting go.
// [R16] Port reads return zero on analog pins.
// [R17] Conversion ignores pin direction bits entirely.
// [R18] Clearing go aborts without touching the result.
// [R19] Two-period recovery wait, then sampling restarts.
// [R20] Software never sets go while switching on.
// [R21] Port configuration resets from the analog strap.
// [R22] Device reset switches off and aborts conversion.
// [R23] Bit period from divider or RC; whole periods. The RC source is not restarted; its first period can be partial.
// [R24] Go set during recovery waits for its end.
//
// Implementation choices: the Avalon-MM register port and the address map.
`timescale 1ns/1ns
`default_nettype none
`include "aacs_regs.vh"

module aacs_sequencer (
    // Clock and reset.
    input  wire                     clk,
    input  wire                     sys_rst,
    // Avalon-MM slave.
    input  wire [`AACS_ADDR_W-1:0]  avs_address,
    input  wire                     avs_read,
    input  wire                     avs_write,
    input  wire [31:0]              avs_writedata,
    input  wire [3:0]               avs_byteenable,
    output reg  [31:0]              avs_readdata_r,
    output reg                      avs_waitrequest_r,
    // Straps and pins.
    input  wire                     portbAnalogResetSel,
    input  wire [`AACS_PINS-1:0]    portPins,
    input  wire                     rcClkPin,
    // Analog sample-and-hold and converter.
    input  wire [`AACS_RES_W-1:0]   convResult,
    output reg                      holdConnect_r,
    output reg                      convActive_r,
    output reg                      convBitStrobe_r,
    output reg  [3:0]               channelSelect_r,
    output reg                      converterOn_r
);

    // Sequencer states.
    localparam ST_IDLE  = 3'h0;
    localparam ST_ACQ   = 3'h1;
    localparam ST_DLY   = 3'h2;
    localparam ST_CONV  = 3'h3;
    localparam ST_RECOV = 3'h4;

    reg  [2:0]              state_r;
    reg  [2:0]              state_nxt;
    reg  [4:0]              cnt_r;
    reg  [4:0]              cnt_nxt;
    reg                     restart_r;
    reg                     restart_nxt;
    reg                     doneEvt;
    reg                     goFlag_r;
    reg                     doneFlag_r;
    reg  [`AACS_RES_W-1:0]  result_r;
    reg  [3:0]              portCfg_r;
    reg  [5:0]              ctrl2_r;
    reg  [1:0]              strapStage_r;
    reg                     strapSync1_r;
    reg                     strapSync2_r;
    reg                     cfgLoaded_r;
    reg  [`AACS_PINS-1:0]   pinSync1_r;
    reg  [`AACS_PINS-1:0]   pinSync2_r;
    reg  [31:0]             readMux;
    wire                    tadRaw;
    wire                    tadTick;
    wire                    wrEn;
    wire                    wrCtrl0;
    wire                    goClr;
    wire                    rcSel;
    wire [2:0]              acqSel;
    wire [4:0]              acqTads;

    // Bit periods of sampling for each acquisition select code.
    function [4:0] acqPeriods;
        input [2:0] sel;
        begin
            case (sel)
                3'h0:    acqPeriods = 5'h00;
                3'h1:    acqPeriods = 5'h02;
                3'h2:    acqPeriods = 5'h04;
                3'h3:    acqPeriods = 5'h06;
                3'h4:    acqPeriods = 5'h08;
                3'h5:    acqPeriods = 5'h0c;
                3'h6:    acqPeriods = 5'h10;
                default: acqPeriods = 5'h14;
            endcase
        end
    endfunction

    // Pins that the configuration code leaves analog, lowest channels first.
    function [`AACS_PINS-1:0] analogMask;
        input [3:0] cfg;
        begin
            if (cfg <= 4'h4) begin
                analogMask = 11'h7ff;
            end else begin
                analogMask = 11'h7ff >> (cfg - 4'h4);
            end
        end
    endfunction

    assign acqSel  = ctrl2_r[`AACS_C2_ACQ_HI:`AACS_C2_ACQ_LO];
    assign acqTads = acqPeriods(acqSel); // see [R5]
    assign rcSel   = (ctrl2_r[1:0] == 2'h3);
    // A tick left over from before a divider restart would cut the first period short.
    assign tadTick = tadRaw & ~restart_r; // see [R23]

    // A write takes effect at the edge where waitrequest is seen low.
    assign wrEn    = avs_write & ~avs_waitrequest_r;
    assign wrCtrl0 = wrEn & avs_byteenable[0] & (avs_address == `AACS_OFS_CTRL0);
    assign goClr   = wrCtrl0 & ~avs_writedata[`AACS_C0_GO];

    aacs_tad_gen u_tad_gen (
        .clk       (clk),
        .sys_rst   (sys_rst),
        .clkSel    (ctrl2_r[`AACS_C2_CS_HI:`AACS_C2_CS_LO]),
        .restart   (restart_r),
        .rcClkPin  (rcClkPin),
        .tadTick_r (tadRaw)
    );

    // Next state of the acquisition, conversion and recovery sequence.
    always @* begin
        state_nxt   = state_r;
        cnt_nxt     = cnt_r;
        restart_nxt = 1'b0;
        doneEvt     = 1'b0;
        case (state_r)
            ST_IDLE: begin
                if (goFlag_r) begin
                    restart_nxt = 1'b1;
                    if (acqTads != 5'h00) begin
                        state_nxt = ST_ACQ; // see [R4]
                        cnt_nxt   = acqTads;
                    end else if (rcSel) begin
                        state_nxt = ST_DLY; // see [R14]
                        cnt_nxt   = `AACS_TCY_OSC - 5'h01;
                    end else begin
                        state_nxt = ST_CONV; // see [R3]
                        cnt_nxt   = `AACS_CONV_TADS;
                    end
                end
            end
            ST_ACQ: begin
                if (goClr) begin
                    state_nxt   = ST_RECOV; // see [R18]
                    cnt_nxt     = `AACS_RECOV_TADS;
                    restart_nxt = 1'b1;
                end else if (tadTick) begin
                    if (cnt_r == 5'h01) begin
                        state_nxt = ST_CONV; // see [R4]
                        cnt_nxt   = `AACS_CONV_TADS;
                    end else begin
                        cnt_nxt = cnt_r - 5'h01;
                    end
                end
            end
            ST_DLY: begin
                if (goClr) begin
                    state_nxt   = ST_RECOV;
                    cnt_nxt     = `AACS_RECOV_TADS;
                    restart_nxt = 1'b1;
                end else if (cnt_r == 5'h00) begin
                    state_nxt   = ST_CONV; // see [R14]
                    cnt_nxt     = `AACS_CONV_TADS;
                    restart_nxt = 1'b1;
                end else begin
                    cnt_nxt = cnt_r - 5'h01;
                end
            end
            ST_CONV: begin
                if (goClr) begin
                    state_nxt   = ST_RECOV; // see [R18]
                    cnt_nxt     = `AACS_RECOV_TADS;
                    restart_nxt = 1'b1;
                end else if (tadTick) begin
                    if (cnt_r == 5'h01) begin
                        doneEvt   = 1'b1; // see [R8]
                        state_nxt = ST_RECOV;
                        cnt_nxt   = `AACS_RECOV_TADS;
                    end else begin
                        cnt_nxt = cnt_r - 5'h01;
                    end
                end
            end
            ST_RECOV: begin
                // A go set meanwhile stays pending in the flag until idle.
                if (tadTick) begin
                    if (cnt_r == 5'h01) begin
                        state_nxt = ST_IDLE; // see [R19] [R24]
                    end else begin
                        cnt_nxt = cnt_r - 5'h01;
                    end
                end
            end
            default: begin
                state_nxt = ST_IDLE;
                cnt_nxt   = 5'h00;
            end
        endcase
        if (!converterOn_r) begin
            state_nxt = ST_IDLE;
            doneEvt   = 1'b0;
        end
    end

    // Sequencer registers, go flag, done flag and result.
    always @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            state_r         <= ST_IDLE; // see [R22]
            cnt_r           <= 5'h00;
            restart_r       <= 1'b0;
            goFlag_r        <= 1'b0;
            doneFlag_r      <= 1'b0;
            result_r        <= `AACS_RES_RST;
            converterOn_r   <= 1'b0; // see [R22]
            channelSelect_r <= `AACS_CHS_RST;
            holdConnect_r   <= 1'b0;
            convActive_r    <= 1'b0;
            convBitStrobe_r <= 1'b0;
        end else begin
            state_r   <= state_nxt;
            cnt_r     <= cnt_nxt;
            restart_r <= restart_nxt;
            if (wrCtrl0) begin
                converterOn_r   <= avs_writedata[`AACS_C0_ON];
                channelSelect_r <= avs_writedata[`AACS_C0_CHS_HI:`AACS_C0_CHS_LO];
                goFlag_r        <= avs_writedata[`AACS_C0_GO] & avs_writedata[`AACS_C0_ON];
            end else if (doneEvt) begin
                goFlag_r <= 1'b0; // see [R6]
            end else if (!converterOn_r) begin
                goFlag_r <= 1'b0;
            end
            // Completion sets the flag even against a clear in the same cycle.
            if (doneEvt) begin
                doneFlag_r <= 1'b1; // see [R6]
            end else if (wrEn && avs_byteenable[0] && (avs_address == `AACS_OFS_STATUS)
                         && avs_writedata[`AACS_ST_DONE]) begin
                doneFlag_r <= 1'b0;
            end
            // Only a completed conversion or software loads the result.
            if (doneEvt) begin
                result_r <= convResult; // see [R18]
            end else if (wrEn && (avs_address == `AACS_OFS_RESULT)) begin
                if (avs_byteenable[0]) begin
                    result_r[7:0] <= avs_writedata[7:0];
                end
                if (avs_byteenable[1]) begin
                    result_r[9:8] <= avs_writedata[9:8];
                end
            end
            // The channel reaches the converter whatever the pin direction is.
            holdConnect_r   <= converterOn_r & ((state_nxt == ST_IDLE) |
                               (state_nxt == ST_ACQ) | (state_nxt == ST_DLY)); // see [R2] [R17]
            convActive_r    <= (state_nxt == ST_CONV); // see [R2]
            convBitStrobe_r <= (state_r == ST_CONV) & tadTick & converterOn_r; // see [R8]
        end
    end

    // Strap and port pins pass two flip-flops before use.
    always @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            strapSync1_r <= 1'b0;
            strapSync2_r <= 1'b0;
            strapStage_r <= 2'h0;
            pinSync1_r   <= 11'h000;
            pinSync2_r   <= 11'h000;
        end else begin
            strapSync1_r <= portbAnalogResetSel;
            strapSync2_r <= strapSync1_r;
            strapStage_r <= {strapStage_r[0], 1'b1};
            pinSync1_r   <= portPins;
            pinSync2_r   <= pinSync1_r;
        end
    end

    // Configuration registers; port configuration is caught from the strap after release.
    always @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            portCfg_r   <= `AACS_CFG_RST_ANA;
            cfgLoaded_r <= 1'b0;
            ctrl2_r     <= `AACS_C2_RST; // see [R3]
        end else begin
            if (!cfgLoaded_r && strapStage_r[1]) begin
                cfgLoaded_r <= 1'b1;
                portCfg_r   <= strapSync2_r ? `AACS_CFG_RST_ANA : `AACS_CFG_RST_DIG; // see [R21]
            end else if (wrEn && avs_byteenable[0] && (avs_address == `AACS_OFS_CTRL1)) begin
                portCfg_r <= avs_writedata[3:0];
            end
            if (wrEn && avs_byteenable[0] && (avs_address == `AACS_OFS_CTRL2)) begin
                ctrl2_r <= avs_writedata[5:0];
            end
        end
    end

    // Read multiplexer; the status word shows only done, and go reads back in control register zero.
    always @* begin
        readMux = 32'h0000_0000;
        case (avs_address)
            `AACS_OFS_CTRL0:  readMux = {26'h0, channelSelect_r, goFlag_r, converterOn_r}; // see [R7]
            `AACS_OFS_CTRL1:  readMux = {28'h0, portCfg_r};
            `AACS_OFS_CTRL2:  readMux = {26'h0, ctrl2_r};
            `AACS_OFS_RESULT: readMux = {22'h0, result_r};
            `AACS_OFS_STATUS: readMux = {31'h0, doneFlag_r};
            `AACS_OFS_PORT:   readMux = {21'h0, pinSync2_r & ~analogMask(portCfg_r)}; // see [R16]
            default:          readMux = 32'h0000_0000;
        endcase
    end

    // Bus handshake: each request sees waitrequest high one cycle, then low one cycle.
    always @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            avs_waitrequest_r <= 1'b1;
            avs_readdata_r    <= 32'h0000_0000;
        end else if ((avs_read || avs_write) && avs_waitrequest_r) begin
            avs_waitrequest_r <= 1'b0;
            avs_readdata_r    <= readMux;
        end else begin
            avs_waitrequest_r <= 1'b1;
        end
    end

endmodule
`default_nettype wire

// file: design/aacs_tad_gen.v
// Conversion bit period generator: oscillator divider or synchronised RC source.
`timescale 1ns/1ns
`default_nettype none
`include "aacs_regs.vh"

module aacs_tad_gen (
    // Clock and reset.
    input  wire       clk,
    input  wire       sys_rst,
    // Control from the sequencer.
    input  wire [2:0] clkSel,
    input  wire       restart,
    // Internal RC oscillator, asynchronous to clk.
    input  wire       rcClkPin,
    // One-cycle pulse at the end of each bit period.
    output reg        tadTick_r
);

    reg  [6:0] divCnt_r;
    reg        rcSync1_r;
    reg        rcSync2_r;
    reg        rcPrev_r;
    wire [6:0] divLast;
    wire       rcSel;

    // Oscillator periods per bit period for each clock select code.
    function [6:0] tadDivisor;
        input [2:0] sel;
        begin
            case (sel)
                3'h0:    tadDivisor = 7'h02;
                3'h4:    tadDivisor = 7'h04;
                3'h1:    tadDivisor = 7'h08;
                3'h5:    tadDivisor = 7'h10;
                3'h2:    tadDivisor = 7'h20;
                3'h6:    tadDivisor = 7'h40;
                default: tadDivisor = 7'h02;
            endcase
        end
    endfunction

    // Codes x11 pick the RC source.
    assign rcSel   = (clkSel[1:0] == 2'h3); // see [R9]
    assign divLast = tadDivisor(clkSel) - 7'h01; // see [R9]

    // Two-stage synchroniser for the RC clock, then an edge register.
    always @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            rcSync1_r <= 1'b0;
            rcSync2_r <= 1'b0;
            rcPrev_r  <= 1'b0;
        end else begin
            rcSync1_r <= rcClkPin;
            rcSync2_r <= rcSync1_r;
            rcPrev_r  <= rcSync2_r;
        end
    end

    // The divider restarts at a phase start so that waits span whole periods.
    always @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            divCnt_r  <= 7'h00;
            tadTick_r <= 1'b0;
        end else if (restart) begin
            divCnt_r  <= 7'h00; // see [R23]
            tadTick_r <= 1'b0;
        end else if (rcSel) begin
            divCnt_r  <= 7'h00;
            tadTick_r <= rcSync2_r & ~rcPrev_r; // see [R23]
        end else if (divCnt_r >= divLast) begin
            divCnt_r  <= 7'h00;
            tadTick_r <= 1'b1; // see [R23]
        end else begin
            divCnt_r  <= divCnt_r + 7'h01;
            tadTick_r <= 1'b0;
        end
    end

endmodule
`default_nettype wire

// file: verif/aacs_analog_model.sv
// Behavioural sample-and-hold and converter facing the sequencer.
`timescale 1ns/1ns
`default_nettype none
module aacs_analog_model (
    // Clock and reset.
    input  wire logic       clk,
    input  wire logic       sys_rst,
    // Sequencer controls.
    input  wire logic       holdConnect,
    input  wire logic       convActive,
    input  wire logic       bitStrobe,
    input  wire logic [3:0] channel,
    // Result and bit count.
    output var  logic [9:0] result,
    output var  logic [4:0] bitCount
);
    logic [9:0] held_r;
    // The level tracks the channel while connected and freezes when cut off.
    always @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            held_r <= 10'h000;
            bitCount <= 5'h00;
        end else begin
            if (holdConnect) held_r <= {channel, 6'h2b};
            if (holdConnect) bitCount <= 5'h00;
            else if (bitStrobe) bitCount <= bitCount + 5'h01;
        end
    end
    // Outside conversion the result lines carry the inverse, never a stale value.
    assign result = convActive ? held_r : ~held_r;
endmodule
`default_nettype wire

// file: verif/aacs_seq_chk.sv
// Concurrent checks on the ports of the sequencer.
`timescale 1ns/1ns
`default_nettype none
module aacs_seq_chk (
    // Clock and reset.
    input wire logic        clk,
    input wire logic        sys_rst,
    // Register bus.
    input wire logic [4:0]  avs_address,
    input wire logic        avs_read,
    input wire logic [31:0] avs_readdata_r,
    input wire logic        avs_waitrequest_r,
    // Converter side.
    input wire logic        holdConnect_r,
    input wire logic        convActive_r,
    input wire logic        convBitStrobe_r,
    input wire logic        converterOn_r
);
    logic [4:0] strobeCnt_r;
    default clocking cb @(posedge clk); endclocking
    default disable iff (sys_rst);
    // Counts bit strobes within one conversion phase.
    always @(posedge clk or posedge sys_rst) begin
        if (sys_rst) strobeCnt_r <= 5'h00;
        else if (convBitStrobe_r) strobeCnt_r <= strobeCnt_r + 5'h01;
        else if (!convActive_r) strobeCnt_r <= 5'h00;
    end
    chk_wait_pulse: assert property (!avs_waitrequest_r |=> avs_waitrequest_r)
        else $error("waitrequest stayed low");
    chk_unmapped_zero: assert property (avs_read && !avs_waitrequest_r && avs_address >= 5'h18
        |-> avs_readdata_r == 32'h0) else $error("unmapped read not zero");
    chk_hold_open: assert property (convActive_r |-> !holdConnect_r)
        else $error("capacitor connected during conversion");
    chk_hold_cut: assert property ($rose(convActive_r) |-> $fell(holdConnect_r))
        else $error("capacitor not cut at conversion start");
    chk_strobe_conv: assert property (convBitStrobe_r
        |-> convActive_r || $past(convActive_r)) else $error("bit strobe outside conversion");
    chk_strobe_gap: assert property (convBitStrobe_r |=> !convBitStrobe_r)
        else $error("bit period shorter than two clocks");
    chk_strobe_count: assert property (strobeCnt_r <= 5'd11)
        else $error("more than eleven bit periods");
    chk_off_idle: assert property (!converterOn_r |=> !convActive_r)
        else $error("conversion while converter off");
    chk_recov_gap: assert property ($fell(convActive_r) && converterOn_r
        |-> !holdConnect_r [*4]) else $error("recovery wait too short");
    cover property ($rose(convActive_r));
    cover property ($fell(convActive_r) && converterOn_r);
    cover property (avs_read && !avs_waitrequest_r);
endmodule
bind aacs_sequencer aacs_seq_chk aacs_seq_chk_inst (.clk(clk), .sys_rst(sys_rst),
    .avs_address(avs_address), .avs_read(avs_read), .avs_readdata_r(avs_readdata_r),
    .avs_waitrequest_r(avs_waitrequest_r), .holdConnect_r(holdConnect_r),
    .convActive_r(convActive_r), .convBitStrobe_r(convBitStrobe_r),
    .converterOn_r(converterOn_r));
`default_nettype wire

// file: verif/aacs_sequencer_bench.sv
// Self-checking bench of the acquisition and conversion sequencer.
`timescale 1ns/1ns
`default_nettype none
`include "aacs_regs.vh"
module aacs_sequencer_bench;
    logic        clk = 1'b0;
    logic        rstIn = 1'b1;
    logic [4:0]  adr = 5'h00;
    logic        rd = 1'b0;
    logic        wr = 1'b0;
    logic [31:0] wd = 32'h0;
    logic        strap = 1'b1;
    logic        rcClk = 1'b0;
    wire  [31:0] rdData;
    wire         waitReq, holdOn, convAct, bitStb, onOut;
    wire  [3:0]  chan;
    wire  [9:0]  result;
    wire  [4:0]  bitCount;
    int          bad_count = 0;
    int          comparisons = 0;
    int          cycles = 0;
    int          cyc;
    logic [31:0] rdVal;
    // System clock and a free-running RC oscillator of unrelated phase.
    always #10 clk = ~clk;
    always #133 rcClk = ~rcClk;
    aacs_sequencer aacs_sequencer_inst (.clk(clk), .sys_rst(rstIn), .avs_address(adr),
        .avs_read(rd), .avs_write(wr), .avs_writedata(wd), .avs_byteenable(4'hf),
        .avs_readdata_r(rdData), .avs_waitrequest_r(waitReq), .portbAnalogResetSel(strap),
        .portPins(11'h7ff), .rcClkPin(rcClk), .convResult(result), .holdConnect_r(holdOn),
        .convActive_r(convAct), .convBitStrobe_r(bitStb), .channelSelect_r(chan),
        .converterOn_r(onOut));
    aacs_analog_model aacs_analog_model_inst (.clk(clk), .sys_rst(rstIn), .holdConnect(holdOn),
        .convActive(convAct), .bitStrobe(bitStb), .channel(chan), .result(result),
        .bitCount(bitCount));
    // Prints the counts and the verdict, then ends the run.
    task automatic stop_test;
        $display("Compared %0d values, %0d wrong", comparisons, bad_count);
        if (bad_count == 0 && comparisons > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask
    // Cuts a hang short.
    always @(posedge clk) begin
        cycles++;
        if (cycles == 40000) begin
            bad_count++;
            stop_test;
        end
    end
    // One Avalon transfer, held until waitrequest is seen low.
    task automatic busOp(input logic w, input logic [4:0] a, input logic [31:0] d);
        @(posedge clk);
        adr <= a;
        wd <= d;
        wr <= w;
        rd <= !w;
        do @(posedge clk); while (waitReq !== 1'b0);
        rdVal = rdData;
        wr <= 1'b0;
        rd <= 1'b0;
    endtask
    task automatic checkEq(input logic [31:0] got, input logic [31:0] exp);
        comparisons++;
        if (got !== exp) begin
            bad_count++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic checkRange(input int got, input int lo, input int hi);
        comparisons++;
        if (got < lo || got > hi) begin
            bad_count++;
            $display("wrong value at %0t: got %h expected %h..%h", $time, got, lo, hi);
        end
    endtask
    task automatic readChk(input logic [4:0] a, input logic [31:0] exp);
        busOp(1'b0, a, 32'h0);
        checkEq(rdVal, exp);
    endtask
    // Counts clock edges until conversion (0) or hold (1) shows the given level.
    task automatic waitSig(input int which, input logic lvl);
        cyc = 0;
        do begin
            @(posedge clk);
            cyc++;
        end while ((which == 0 ? convAct : holdOn) !== lvl);
    endtask
    // One full conversion on channel 5 with start and length windows.
    task automatic runConv(input logic [2:0] cs, input logic [2:0] acq, input int lo, hi, clo, chi);
        busOp(1'b1, `AACS_OFS_CTRL2, {26'h0, acq, cs});
        busOp(1'b1, `AACS_OFS_CTRL0, 32'h15);
        busOp(1'b1, `AACS_OFS_CTRL0, 32'h17);
        waitSig(0, 1'b1);
        checkRange(cyc, lo, hi);
        waitSig(0, 1'b0);
        checkRange(cyc, clo, chi);
        @(posedge clk); // The model counts the last strobe one edge after the phase ends.
        checkEq(32'(bitCount), 32'd11);
        waitSig(1, 1'b1);
        readChk(`AACS_OFS_RESULT, 32'h16b);
        readChk(`AACS_OFS_CTRL0, 32'h15);
        readChk(`AACS_OFS_STATUS, 32'h1);
        busOp(1'b1, `AACS_OFS_STATUS, 32'h1);
        readChk(`AACS_OFS_STATUS, 32'h0);
    endtask
    task automatic testReset;
        readChk(`AACS_OFS_CTRL1, 32'h0);
        readChk(`AACS_OFS_CTRL2, 32'h0);
        readChk(`AACS_OFS_RESULT, 32'h0);
        busOp(1'b1, 5'h1c, 32'hffff_ffff);
        readChk(5'h1c, 32'h0);
    endtask
    task automatic testPort;
        logic [3:0] cfg[4] = '{4'h0, 4'hb, 4'hf, 4'h7};
        logic [10:0] exp[4] = '{11'h000, 11'h7f0, 11'h7ff, 11'h700};
        for (int i = 0; i < 4; i++) begin
            busOp(1'b1, `AACS_OFS_CTRL1, {28'h0, cfg[i]});
            readChk(`AACS_OFS_PORT, {21'h0, exp[i]});
        end
    endtask
    task automatic testAcq;
        int acqT[8] = '{0, 2, 4, 6, 8, 12, 16, 20};
        for (int i = 0; i < 8; i++)
            runConv(3'h0, i[2:0], 2 * acqT[i], 2 * acqT[i] + 4, 21, 24);
    endtask
    task automatic testClocks;
        logic [2:0] cs[6] = '{3'h0, 3'h4, 3'h1, 3'h5, 3'h2, 3'h6};
        int div[6] = '{2, 4, 8, 16, 32, 64};
        for (int i = 0; i < 6; i++)
            runConv(cs[i], 3'h0, 0, 4, 11 * div[i] - 1, 11 * div[i] + 2);
        runConv(3'h3, 3'h0, 4, 9, 130, 170);
        runConv(3'h7, 3'h0, 4, 9, 130, 170);
    endtask
    task automatic testAbort;
        busOp(1'b1, `AACS_OFS_RESULT, 32'h2a5);
        busOp(1'b1, `AACS_OFS_CTRL2, 32'h06);
        busOp(1'b1, `AACS_OFS_CTRL0, 32'h17);
        waitSig(0, 1'b1);
        repeat (100) @(posedge clk);
        busOp(1'b1, `AACS_OFS_CTRL0, 32'h15);
        waitSig(0, 1'b0);
        checkRange(cyc, 0, 3);
        waitSig(1, 1'b1);
        checkRange(cyc, 124, 134);
        readChk(`AACS_OFS_RESULT, 32'h2a5);
        readChk(`AACS_OFS_STATUS, 32'h0);
    endtask
    task automatic testRecovGo;
        busOp(1'b1, `AACS_OFS_CTRL0, 32'h17);
        waitSig(0, 1'b1);
        waitSig(0, 1'b0);
        busOp(1'b1, `AACS_OFS_CTRL0, 32'h17);
        waitSig(0, 1'b1);
        checkRange(cyc, 118, 134);
        waitSig(0, 1'b0);
        busOp(1'b1, `AACS_OFS_STATUS, 32'h1);
    endtask
    task automatic testResetMid;
        strap <= 1'b0;
        busOp(1'b1, `AACS_OFS_CTRL0, 32'h17);
        waitSig(0, 1'b1);
        rstIn <= 1'b1;
        @(negedge clk);
        checkEq({30'h0, convAct, onOut}, 32'h0);
        @(posedge clk);
        rstIn <= 1'b0;
        repeat (5) @(posedge clk);
        readChk(`AACS_OFS_CTRL1, 32'h7);
        readChk(`AACS_OFS_CTRL0, 32'h0);
    endtask
    // Reset, then every scenario in turn.
    initial begin
        repeat (5) @(posedge clk);
        rstIn <= 1'b0;
        repeat (4) @(posedge clk);
        testReset;
        testPort;
        testAcq;
        testClocks;
        testAbort;
        testRecovGo;
        testResetMid;
        stop_test;
    end
endmodule
`default_nettype wire
